// *** inc/ppdio_map.vh ***
`ifndef PPDIO_MAP_VH
`define PPDIO_MAP_VH
// low-nibble register offsets
`define PPDIO_OFS_X_DATA     4'h0
`define PPDIO_OFS_X_DIR      4'h1
`define PPDIO_OFS_Y_DATA     4'h2
`define PPDIO_OFS_Y_DIR      4'h3
`define PPDIO_OFS_Z_DATA     4'h4
`define PPDIO_OFS_Z_DIR      4'h5
`define PPDIO_OFS_HS_CTRL    4'h6
`define PPDIO_OFS_PIN_CTRL   4'h7
`define PPDIO_OFS_MAP        4'hf
// full address of the mapping register, valid before mapping
`define PPDIO_MAP_ADDR       8'hff
// reset values
`define PPDIO_RST_DIR        8'h00
`define PPDIO_RST_CTRL       8'h00
`define PPDIO_RST_DATA       8'h00
// handshake control fields
`define PPDIO_HS_X_EN_BIT    7
`define PPDIO_HS_X_EDGE_BIT  6
`define PPDIO_HS_Y_EN_BIT    3
`define PPDIO_HS_Y_EDGE_BIT  2
// pin function control fields
`define PPDIO_PF_XIN_BIT     0
`define PPDIO_PF_YIN_BIT     2
`endif

// *** rtl/ppdio_port.v ***
`timescale 1ns/1ps
`include "ppdio_map.vh"
// Contract
// - three 8-bit ports, each pin direction set by its direction bit
// - direction bit one drives the pin with the stored data bit
// - direction bit zero releases the pin as a high-impedance input
// - reset clears all direction bits so every pin starts as input
// - eight port registers: three data, three direction, two control
// - mapping register takes one write after reset, later writes ignored
// - access decoded only when upper address nibble matches stored base
module ppdio_port #(
  parameter W = 8
) (
  // clock and reset
  input  wire         clk,
  input  wire         arst_n,
  // multiplexed host bus (synchronous to clk)
  input  wire         addrLatch,
  input  wire         busEnable,
  input  wire         readNotWrite,
  input  wire [7:0]   adIn,
  output reg  [7:0]   adOut,
  output reg          adOen_n,
  // chain reset out
  output reg          chainResetOut,
  // ports, 3*W wide: X in [W-1:0], Y next, Z top
  input  wire [3*W-1:0] portIn,
  output reg  [3*W-1:0] portOut,
  output reg  [3*W-1:0] portOen_n,
  // handshake edge flags
  output reg          xEdgeFlag,
  output reg          yEdgeFlag
);

  reg  [7:0]     addr_r;
  reg  [3:0]     base_r;
  reg            mapped_r;
  reg  [3*W-1:0] data_r;
  reg  [3*W-1:0] dir_r;
  reg  [7:0]     hsCtrl_r;
  reg  [7:0]     pfCtrl_r;
  reg  [3*W-1:0] pinS1_r;
  reg  [3*W-1:0] pinS2_r;
  reg            xPrev_r;
  reg            yPrev_r;
  reg            enPrev_r;
  reg  [7:0]     rd_nxt;

  wire           strobe   = busEnable & ~enPrev_r;
  wire           hit      = mapped_r & (addr_r[7:4] == base_r);
  wire [3:0]     ofs      = addr_r[3:0];
  wire           wr       = strobe & ~readNotWrite;
  wire           rd       = strobe & readNotWrite;
  wire           mapWr    = wr & ~mapped_r & (addr_r == `PPDIO_MAP_ADDR);
  // pin values seen by reads: input bits from pins, output bits stored
  wire [3*W-1:0] readback = (dir_r & data_r) | (~dir_r & pinS2_r);
  // handshake input pins sit on port Z bits 0 and 2
  wire           xPin     = pinS2_r[2*W+`PPDIO_PF_XIN_BIT];
  wire           yPin     = pinS2_r[2*W+`PPDIO_PF_YIN_BIT];
  wire           xEdge    = hsCtrl_r[`PPDIO_HS_X_EDGE_BIT] ? (xPin & ~xPrev_r)
                                                            : (~xPin & xPrev_r);
  wire           yEdge    = hsCtrl_r[`PPDIO_HS_Y_EDGE_BIT] ? (yPin & ~yPrev_r)
                                                            : (~yPin & yPrev_r);
  wire           xActive  = pfCtrl_r[`PPDIO_PF_XIN_BIT];
  wire           yActive  = pfCtrl_r[`PPDIO_PF_YIN_BIT];
  wire           xAccess  = strobe & hit & (ofs == `PPDIO_OFS_X_DATA);
  wire           yAccess  = strobe & hit & (ofs == `PPDIO_OFS_Y_DATA);

  always @* begin
    rd_nxt = 8'h00;
    case (ofs)
      `PPDIO_OFS_X_DATA:   rd_nxt = readback[W-1:0];
      `PPDIO_OFS_X_DIR:    rd_nxt = dir_r[W-1:0];
      `PPDIO_OFS_Y_DATA:   rd_nxt = readback[2*W-1:W];
      `PPDIO_OFS_Y_DIR:    rd_nxt = dir_r[2*W-1:W];
      `PPDIO_OFS_Z_DATA:   rd_nxt = readback[3*W-1:2*W];
      `PPDIO_OFS_Z_DIR:    rd_nxt = dir_r[3*W-1:2*W];
      `PPDIO_OFS_HS_CTRL:  rd_nxt = hsCtrl_r;
      `PPDIO_OFS_PIN_CTRL: rd_nxt = pfCtrl_r;
      default:             rd_nxt = 8'h00;
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_r        <= 8'h00;
      base_r        <= 4'h0;
      mapped_r      <= 1'b0;
      chainResetOut <= 1'b0;
      data_r        <= {3{`PPDIO_RST_DATA}};
      dir_r         <= {3{`PPDIO_RST_DIR}};
      hsCtrl_r      <= `PPDIO_RST_CTRL;
      pfCtrl_r      <= `PPDIO_RST_CTRL;
      pinS1_r       <= {3*W{1'b0}};
      pinS2_r       <= {3*W{1'b0}};
      xPrev_r       <= 1'b0;
      yPrev_r       <= 1'b0;
      enPrev_r      <= 1'b0;
      adOut         <= 8'h00;
      adOen_n       <= 1'b1;
      portOut       <= {3*W{1'b0}};
      portOen_n     <= {3*W{1'b1}};
      xEdgeFlag     <= 1'b0;
      yEdgeFlag     <= 1'b0;
    end else begin
      pinS1_r  <= portIn;
      pinS2_r  <= pinS1_r;
      xPrev_r  <= xPin;
      yPrev_r  <= yPin;
      enPrev_r <= busEnable;
      if (addrLatch)
        addr_r <= adIn;
      if (mapWr) begin
        base_r        <= adIn[3:0];
        mapped_r      <= 1'b1;
        chainResetOut <= 1'b1;
      end
      if (wr & hit) begin
        case (ofs)
          `PPDIO_OFS_X_DATA:   data_r[W-1:0]     <= adIn[W-1:0];
          `PPDIO_OFS_X_DIR:    dir_r[W-1:0]      <= adIn[W-1:0];
          `PPDIO_OFS_Y_DATA:   data_r[2*W-1:W]   <= adIn[W-1:0];
          `PPDIO_OFS_Y_DIR:    dir_r[2*W-1:W]    <= adIn[W-1:0];
          `PPDIO_OFS_Z_DATA:   data_r[3*W-1:2*W] <= adIn[W-1:0];
          `PPDIO_OFS_Z_DIR:    dir_r[3*W-1:2*W]  <= adIn[W-1:0];
          `PPDIO_OFS_HS_CTRL:  hsCtrl_r          <= adIn;
          `PPDIO_OFS_PIN_CTRL: pfCtrl_r          <= adIn;
          default:             hsCtrl_r          <= hsCtrl_r;
        endcase
      end
      if (rd & hit) begin
        adOut   <= rd_nxt;
        adOen_n <= 1'b0;
      end else if (!busEnable) begin
        adOen_n <= 1'b1;
      end
      portOut   <= data_r;
      portOen_n <= ~dir_r;
      // set wins over the access clear
      if (xActive & xEdge)
        xEdgeFlag <= 1'b1;
      else if (xAccess)
        xEdgeFlag <= 1'b0;
      if (yActive & yEdge)
        yEdgeFlag <= 1'b1;
      else if (yAccess)
        yEdgeFlag <= 1'b0;
    end
  end

endmodule // ppdio_port

// *** verif/ppdio_port_assertions.sv ***
`timescale 1ns/1ps
module ppdio_port_chk (
  // watched ports of the block
  input wire        clk,
  input wire        arst_n,
  input wire        busEnable,
  input wire        readNotWrite,
  input wire        adOen_n,
  input wire        chainResetOut,
  input wire [23:0] portOut,
  input wire [23:0] portOen_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence sWr; busEnable && !readNotWrite; endsequence
  sequence sStrobeWr; !busEnable ##1 sWr; endsequence
  AST_RST_IN: assert property ($rose(arst_n) |-> &portOen_n) else $error("pins driven");
  // pins follow the register one edge after the strobe edge that wrote it
  AST_DIR_SRC: assert property ($changed(portOen_n) |->
    $past(busEnable && !readNotWrite, 2)) else $error("direction moved alone");
  AST_OUT_SRC: assert property ($changed(portOut) |->
    $past(busEnable && !readNotWrite, 2)) else $error("pin data moved alone");
  AST_MAP_HOLD: assert property (chainResetOut |=> chainResetOut) else $error("map lost");
  AST_MAP_SET: assert property ($rose(chainResetOut) |->
    $past(busEnable && !readNotWrite)) else $error("map set alone");
  AST_NO_ANS: assert property (!chainResetOut |-> adOen_n) else $error("unmapped answer");
  AST_WR_QUIET: assert property (sStrobeWr |=> adOen_n [*2]) else $error("write drove bus");
  AST_RD_SRC: assert property ($fell(adOen_n) |->
    $past(busEnable && readNotWrite)) else $error("answer without read");
  AST_REL: assert property (!busEnable && !adOen_n |=> adOen_n) else $error("bus held");
endmodule // ppdio_port_chk
bind ppdio_port ppdio_port_chk ppdio_port_chk_inst (.clk(clk), .arst_n(arst_n),
  .busEnable(busEnable), .readNotWrite(readNotWrite), .adOen_n(adOen_n),
  .chainResetOut(chainResetOut), .portOut(portOut), .portOen_n(portOen_n));

// *** verif/ppdio_pin_model.sv ***
`timescale 1ns/1ps
module ppdio_pin_model (
  // pins as seen by the far device
  input  wire [23:0] portOut,
  input  wire [23:0] portOen_n,
  input  wire [23:0] extLevel,
  output wire [23:0] portIn
);
  // released pins carry the far level, driven pins the block's own
  assign portIn = (portOut & ~portOen_n) | (extLevel & portOen_n);
endmodule // ppdio_pin_model

// *** verif/ppdio_port_test.sv ***
`timescale 1ns/1ps
module ppdio_port_test;
  reg         clk = 0, arst_n = 0, addrLatch = 0, busEnable = 0, readNotWrite = 0, qOe = 1;
  reg  [7:0]  adIn = 8'h00, q = 8'h00, p;
  reg  [23:0] extLevel = 24'h000000;
  wire [7:0]  adOut;
  wire        adOen_n, chainResetOut, xEdgeFlag, yEdgeFlag;
  wire [23:0] portIn, portOut, portOen_n;
  integer     err_total = 0, total_checks = 0;
  always #2.5 clk = ~clk;
  ppdio_port ppdio_port_inst (.clk(clk), .arst_n(arst_n), .addrLatch(addrLatch),
    .busEnable(busEnable), .readNotWrite(readNotWrite), .adIn(adIn), .adOut(adOut),
    .adOen_n(adOen_n), .chainResetOut(chainResetOut), .portIn(portIn), .portOut(portOut),
    .portOen_n(portOen_n), .xEdgeFlag(xEdgeFlag), .yEdgeFlag(yEdgeFlag));
  ppdio_pin_model ppdio_pin_model_inst (.portOut(portOut), .portOen_n(portOen_n),
    .extLevel(extLevel), .portIn(portIn));
  task chk(input ok);
    begin
      total_checks = total_checks + 1;
      if (!ok) begin
        err_total = err_total + 1;
        $display("MISMATCH %0t: bad value", $time);
      end
    end
  endtask
  // enable is held over the answer edge, then dropped for at least two idle edges before the next access
  task acc(input [7:0] a, input rnw, input [7:0] d);
    begin
      @(posedge clk) #1 addrLatch = 1;
      adIn = a;
      @(posedge clk) #1 addrLatch = 0;
      {busEnable, readNotWrite, adIn} = {1'b1, rnw, d};
      repeat (2) @(posedge clk);
      #1 {q, qOe} = {adOut, adOen_n};
      busEnable = 0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      acc(a, 1, 8'h00);
      chk(qOe === 1'b0 && q === e);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #20000 err_total = err_total + 1;
    test_done;
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 arst_n = 1;
    chk(portOen_n === 24'hffffff);
    acc(8'h50, 1, 8'h00);
    chk(qOe === 1'b1);
    acc(8'hff, 0, 8'h05);
    chk(chainResetOut === 1'b1);
    acc(8'hff, 0, 8'h03);
    acc(8'h31, 0, 8'hff);
    chk(portOen_n === 24'hffffff);
    extLevel = 24'h3c3c3c;
    for (p = 0; p < 3; p = p + 1) begin
      acc(8'h51 + p + p, 0, 8'h0f);
      acc(8'h50 + p + p, 0, 8'ha5);
      rd(8'h51 + p + p, 8'h0f);
      rd(8'h50 + p + p, 8'h35);
      chk(portOen_n[8*p +: 8] === 8'hf0 && (portOut[8*p +: 8] & 8'h0f) === 8'h05);
    end
    rd(8'h56, 8'h00);
    rd(8'h57, 8'h00);
    acc(8'h55, 0, 8'h00);
    acc(8'h56, 0, 8'h40);
    acc(8'h57, 0, 8'h01);
    extLevel[16] = 1'b1;
    repeat (6) @(posedge clk);
    chk(xEdgeFlag === 1'b1 && yEdgeFlag === 1'b0);
    rd(8'h50, 8'h35);
    chk(xEdgeFlag === 1'b0);
    acc(8'h57, 0, 8'h05);
    extLevel[18] = 1'b0;
    repeat (6) @(posedge clk);
    chk(yEdgeFlag === 1'b1 && xEdgeFlag === 1'b0);
    rd(8'h52, 8'h35);
    chk(yEdgeFlag === 1'b0);
    // reset in mid-run: pins released, mapping open to one new write
    @(posedge clk) #1 arst_n = 0;
    repeat (10) @(posedge clk);
    #1 arst_n = 1;
    chk(portOen_n === 24'hffffff && chainResetOut === 1'b0);
    acc(8'hff, 0, 8'h03);
    acc(8'h31, 0, 8'hff);
    rd(8'h31, 8'hff);
    chk(portOen_n === 24'hffff00 && yEdgeFlag === 1'b0);
    test_done;
  end
endmodule // ppdio_port_test
